// ===== inc/cpu_ops_regs.svh
// Constants for the add, shift, bit and branch execution block
`ifndef CPU_OPS_REGS_SVH
`define CPU_OPS_REGS_SVH
`define FILE_ADDR_W   7
`define DATA_W        8
`define PC_W          15
`define BRANCH_OFS_W  9
`define BIT_SEL_W     3
`define HALF_BIT      4
`define PC_RESET      15'h0000
`define ACCUM_RESET   8'h00
`endif

// ===== inc/cpu_ops_pkg.sv
// Types shared by the execution block and its arithmetic unit
package cpu_ops_pkg;
  typedef enum logic [2:0] {
    op_none,
    add_accum_to_file_op,
    add_with_carry_to_file_op,
    arith_shift_right_op,
    bit_clear_op,
    skip_if_bit_low_op,
    rel_jump_op
  } op_t;
  typedef struct packed {
    logic carry;
    logic half;
    logic zero;
  } flags_t;
endpackage : cpu_ops_pkg

// ===== inc/alu_if.sv
// Operand and result bundle between the execution block and its arithmetic unit
`timescale 1ns/1ps
`include "cpu_ops_regs.svh"
interface alu_if;
  import cpu_ops_pkg::*;
  op_t                 op;
  logic [`DATA_W-1:0]  accum;
  logic [`DATA_W-1:0]  fval;
  logic [2:0]          bsel;
  logic                cin;
  logic [`DATA_W-1:0]  result;
  flags_t              flags_out;
  modport core (output op, accum, fval, bsel, cin, input result, flags_out);
  modport alu  (input op, accum, fval, bsel, cin, output result, flags_out);
endinterface : alu_if

// ===== logic/op_alu.sv
// Combinational arithmetic unit: add, add with carry, shift, bit clear
`timescale 1ns/1ps
`include "cpu_ops_regs.svh"
module op_alu (
  // Operand and result bundle
  alu_if.alu a
);
  import cpu_ops_pkg::*;
  logic [`DATA_W:0]   sum;
  logic [`HALF_BIT:0] half_sum;
  logic               cin_eff;
  always_comb begin
    cin_eff     = (a.op == add_with_carry_to_file_op) ? a.cin : 1'b0;
    sum         = {1'b0, a.accum} + {1'b0, a.fval} + {8'h00, cin_eff};
    half_sum    = {1'b0, a.accum[3:0]} + {1'b0, a.fval[3:0]} + {4'h0, cin_eff};
    a.result    = a.fval;
    a.flags_out = '{carry: a.cin, half: 1'b0, zero: 1'b0};
    case (a.op)
      add_accum_to_file_op, add_with_carry_to_file_op: begin
        a.result          = sum[`DATA_W-1:0];
        a.flags_out.carry = sum[`DATA_W];
        a.flags_out.half  = half_sum[`HALF_BIT];
      end
      arith_shift_right_op: begin
        a.result          = {a.fval[7], a.fval[7:1]};
        a.flags_out.carry = a.fval[0];
      end
      bit_clear_op: begin
        a.result          = a.fval & ~(8'h01 << a.bsel);
      end
      default: begin
        a.result          = a.fval;
      end
    endcase
    a.flags_out.zero = (a.result == 8'h00);
  end
endmodule : op_alu

// ===== logic/cpu_exec.sv
// Execution stage for add, add with carry, shift, bit clear, bit skip, branch
//
// Functional notes
// - Add accumulator and file register 0..127; update carry, half, zero flags.
// - Add result to accumulator when dest is 0, to file when 1.
// - Add with carry sums accumulator, file register and carry; updates three flags.
// - Add with carry writes accumulator if dest clear, else data memory.
// - Shift right keeps bit 7, bit 0 to carry; only carry and zero change.
// - Bit clear zeroes selected bit 0..7; other bits and all flags unchanged.
// - Skip test: bit one runs next op; bit zero discards it, two cycles.
// - Branch loads incremented counter plus signed 9-bit offset; flags untouched.
// - Branch always takes two cycles; fetched instruction is flushed.
// - Any branch or taken skip spends an idle second cycle.
`timescale 1ns/1ps
`include "cpu_ops_regs.svh"
module cpu_exec (
  // Clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_arst_n,
  // Decoded instruction
  input  wire logic                      i_valid,
  input  wire cpu_ops_pkg::op_t          i_op,
  input  wire logic [`FILE_ADDR_W-1:0]   i_faddr,
  input  wire logic                      i_dest,
  input  wire logic [`BIT_SEL_W-1:0]     i_bsel,
  input  wire logic [`BRANCH_OFS_W-1:0]  i_offset,
  // Data memory read value at i_faddr
  input  wire logic [`DATA_W-1:0]        i_fdata,
  // Data memory write
  output logic                           o_fwr,
  output logic [`FILE_ADDR_W-1:0]        o_fwr_addr,
  output logic [`DATA_W-1:0]             o_fwr_data,
  // Core state
  output logic [`DATA_W-1:0]             o_accum,
  output logic                           o_carry,
  output logic                           o_half_overflow_bit,
  output logic                           o_zero,
  output logic [`PC_W-1:0]               o_program_counter,
  output logic                           o_idle_slot
);
  import cpu_ops_pkg::*;

  // ********************************************************
  // Arithmetic unit
  // ********************************************************
  alu_if a ();
  op_alu u_alu (
    .a (a)
  );

  // ********************************************************
  // Next state
  // ********************************************************
  logic                    fwr, next_fwr;
  logic [`FILE_ADDR_W-1:0] fwr_addr, next_fwr_addr;
  logic [`DATA_W-1:0]      fwr_data, next_fwr_data;
  logic [`DATA_W-1:0]      accum, next_accum;
  logic                    carry, next_carry;
  logic                    half, next_half;
  logic                    zero, next_zero;
  logic [`PC_W-1:0]        pc, next_pc;
  logic                    idle, next_idle;
  logic                    run;

  always_comb begin
    // An idle slot swallows whatever decode presents: that is the flushed fetch
    run           = i_valid && !idle;
    a.op          = run ? i_op : op_none;
    a.accum       = accum;
    a.fval        = i_fdata;
    a.bsel        = i_bsel;
    a.cin         = carry;
    next_fwr      = 1'b0;
    next_fwr_addr = fwr_addr;
    next_fwr_data = fwr_data;
    next_accum    = accum;
    next_carry    = carry;
    next_half     = half;
    next_zero     = zero;
    next_pc       = pc;
    next_idle     = 1'b0;
    if (idle) begin
      next_pc = pc;
    end else if (run) begin
      next_pc = pc + 15'h0001;
      case (i_op)
        add_accum_to_file_op, add_with_carry_to_file_op: begin
          next_carry = a.flags_out.carry;
          next_half  = a.flags_out.half;
          next_zero  = a.flags_out.zero;
          if (i_dest) begin
            next_fwr      = 1'b1;
            next_fwr_addr = i_faddr;
            next_fwr_data = a.result;
          end else begin
            next_accum = a.result;
          end
        end
        arith_shift_right_op: begin
          next_carry = a.flags_out.carry;
          next_zero  = a.flags_out.zero;
          if (i_dest) begin
            next_fwr      = 1'b1;
            next_fwr_addr = i_faddr;
            next_fwr_data = a.result;
          end else begin
            next_accum = a.result;
          end
        end
        bit_clear_op: begin
          next_fwr      = 1'b1;
          next_fwr_addr = i_faddr;
          next_fwr_data = a.result;
        end
        skip_if_bit_low_op: begin
          if (!i_fdata[i_bsel]) begin
            next_pc   = pc + 15'h0002;
            next_idle = 1'b1;
          end
        end
        rel_jump_op: begin
          next_pc   = pc + 15'h0001 + {{(`PC_W-`BRANCH_OFS_W){i_offset[8]}}, i_offset};
          next_idle = 1'b1;
        end
        default: begin
          next_pc = pc + 15'h0001;
        end
      endcase
    end
  end

  // ********************************************************
  // Registers
  // ********************************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fwr      <= 1'b0;
      fwr_addr <= '0;
      fwr_data <= 8'h00;
      accum    <= `ACCUM_RESET;
      carry    <= 1'b0;
      half     <= 1'b0;
      zero     <= 1'b0;
      pc       <= `PC_RESET;
      idle     <= 1'b0;
    end else begin
      fwr      <= next_fwr;
      fwr_addr <= next_fwr_addr;
      fwr_data <= next_fwr_data;
      accum    <= next_accum;
      carry    <= next_carry;
      half     <= next_half;
      zero     <= next_zero;
      pc       <= next_pc;
      idle     <= next_idle;
    end
  end

  assign o_fwr               = fwr;
  assign o_fwr_addr          = fwr_addr;
  assign o_fwr_data          = fwr_data;
  assign o_accum             = accum;
  assign o_carry             = carry;
  assign o_half_overflow_bit = half;
  assign o_zero              = zero;
  assign o_program_counter   = pc;
  assign o_idle_slot         = idle;

  // ********************************************************
  // Checks
  // ********************************************************
  add_dest_acc_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (run && i_op == add_accum_to_file_op && !i_dest)
      |=> (accum == 8'($past(a.accum) + $past(i_fdata))) && !fwr)
    else $error("add to accumulator wrong");
  add_dest_file_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (run && i_op == add_with_carry_to_file_op && i_dest)
      |=> fwr && fwr_data == 8'($past(a.accum) + $past(i_fdata) + 8'($past(carry))) && $stable(accum))
    else $error("add with carry to file wrong");
  add_carry_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (run && i_op == add_accum_to_file_op)
      |=> carry == (({1'b0, $past(accum)} + {1'b0, $past(i_fdata)}) > 9'h0ff))
    else $error("carry out of bit 7 wrong");
  shift_flags_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (run && i_op == arith_shift_right_op)
      |=> carry == $past(i_fdata[0]) && $stable(half))
    else $error("shift flags wrong");
  clear_bit_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (run && i_op == bit_clear_op)
      |=> fwr && fwr_data[$past(i_bsel)] == 1'b0 && fwr_addr == $past(i_faddr)
          && ((fwr_data | (8'h01 << $past(i_bsel))) == ($past(i_fdata) | (8'h01 << $past(i_bsel))))
          && $stable(carry) && $stable(zero) && $stable(half))
    else $error("bit clear wrong");
  skip_taken_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (run && i_op == skip_if_bit_low_op && !i_fdata[i_bsel])
      |=> idle ##1 !idle)
    else $error("skip did not idle one cycle");
  skip_not_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (run && i_op == skip_if_bit_low_op && i_fdata[i_bsel]) |=> !idle && pc == $past(pc) + 15'h0001)
    else $error("untaken skip stalled");
  jump_target_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (run && i_op == rel_jump_op)
      |=> idle && pc == 15'($past(pc) + 15'h0001 + {{6{$past(i_offset[8])}}, $past(i_offset)}) ##1 $stable(pc))
    else $error("branch target or idle wrong");
  idle_no_write_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    idle |=> !fwr && $stable(accum) && $stable(carry))
    else $error("idle slot changed state");
endmodule : cpu_exec

// ===== verification/tb_cpu_exec.sv
// Self-checking bench for the add, shift, bit and branch execution block
`timescale 1ns/1ps
module tb_cpu_exec;
  import cpu_ops_pkg::*;
  typedef struct packed {
    logic        fwr;
    logic [6:0]  addr;
    logic [7:0]  data;
    logic [7:0]  accum;
    logic [2:0]  flags;
    logic [14:0] pc;
    logic        idle;
  } note_t;
  logic        i_clk    = 1'b0;
  logic        i_arst_n = 1'b0;
  logic        i_valid  = 1'b0;
  op_t         i_op     = op_none;
  logic [6:0]  i_faddr  = 7'h00;
  logic        i_dest   = 1'b0;
  logic [2:0]  i_bsel   = 3'h0;
  logic [8:0]  i_offset = 9'h000;
  logic [7:0]  i_fdata  = 8'h00;
  logic        o_fwr, o_carry, o_half_overflow_bit, o_zero, o_idle_slot;
  logic [6:0]  o_fwr_addr;
  logic [7:0]  o_fwr_data, o_accum;
  logic [14:0] o_program_counter;
  integer      seed        = 32'h38602505;
  int          n_fail      = 0;
  int          comparisons = 0;
  note_t       notes[$];
  note_t       exp_n;
  logic        seen  = 1'b0;
  // Reference state, advanced by the driver in issue order
  logic [7:0]  m_acc = 8'h00;
  logic        m_c = 1'b0, m_h = 1'b0, m_z = 1'b0, m_idle = 1'b0;
  logic [14:0] m_pc  = 15'h0000;

  cpu_exec i_cpu_exec (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_valid(i_valid), .i_op(i_op), .i_faddr(i_faddr),
    .i_dest(i_dest), .i_bsel(i_bsel), .i_offset(i_offset), .i_fdata(i_fdata), .o_fwr(o_fwr),
    .o_fwr_addr(o_fwr_addr), .o_fwr_data(o_fwr_data), .o_accum(o_accum), .o_carry(o_carry),
    .o_half_overflow_bit(o_half_overflow_bit), .o_zero(o_zero), .o_program_counter(o_program_counter),
    .o_idle_slot(o_idle_slot));

  always #10 i_clk = ~i_clk;

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // ****************************************
  // Stimulus and expected results
  // ****************************************
  task automatic issue(input op_t op, input logic [7:0] fd, input logic d, input logic [2:0] b, input logic [8:0] ofs);
    logic [6:0] fa;
    logic [8:0] s;
    logic       cin;
    note_t      n;
    fa     = 7'($random(seed));
    cin    = (op == add_with_carry_to_file_op) ? m_c : 1'b0;
    n      = '0;
    n.addr = fa;
    if (m_idle) begin
      m_idle = 1'b0;
    end else begin
      m_pc = m_pc + 15'h0001;
      case (op)
        add_accum_to_file_op, add_with_carry_to_file_op: begin
          s      = {1'b0, m_acc} + {1'b0, fd} + {8'h00, cin};
          m_h    = ({1'b0, m_acc[3:0]} + {1'b0, fd[3:0]} + {4'h0, cin}) > 5'h0f;
          m_c    = s[8];
          m_z    = (s[7:0] == 8'h00);
          n.data = s[7:0];
        end
        arith_shift_right_op: begin
          n.data = {fd[7], fd[7:1]};
          m_c    = fd[0];
          m_z    = (n.data == 8'h00);
        end
        bit_clear_op: n.data = fd & ~(8'h01 << b);
        skip_if_bit_low_op: if (!fd[b]) begin
          m_pc   = m_pc + 15'h0001;
          m_idle = 1'b1;
        end
        default: begin
          m_pc   = m_pc + {{6{ofs[8]}}, ofs};
          m_idle = 1'b1;
        end
      endcase
      if (op == bit_clear_op ||
          (d && op inside {add_accum_to_file_op, add_with_carry_to_file_op, arith_shift_right_op}))
        n.fwr = 1'b1;
      else if (op inside {add_accum_to_file_op, add_with_carry_to_file_op, arith_shift_right_op})
        m_acc = n.data;
    end
    n.accum = m_acc;
    n.flags = {m_c, m_h, m_z};
    n.pc    = m_pc;
    n.idle  = m_idle;
    notes.push_back(n);
    @(posedge i_clk);
    i_valid  <= 1'b1;
    i_op     <= op;
    i_faddr  <= fa;
    i_dest   <= d;
    i_bsel   <= b;
    i_offset <= ofs;
    i_fdata  <= fd;
  endtask : issue

  initial begin
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(negedge i_clk);
    check(16'({o_accum, o_carry, o_half_overflow_bit, o_zero, o_fwr, o_idle_slot}), 16'h0000);
    check(16'(o_program_counter), 16'h0000);
    // Carry chain, wrap, then bit ops and skips, then branches at both range ends back to back
    issue(add_accum_to_file_op, 8'hff, 1'b0, 3'h0, 9'h000);
    issue(add_accum_to_file_op, 8'h01, 1'b1, 3'h0, 9'h000);
    issue(add_with_carry_to_file_op, 8'h00, 1'b0, 3'h0, 9'h000);
    issue(arith_shift_right_op, 8'h81, 1'b0, 3'h0, 9'h000);
    issue(bit_clear_op, 8'hff, 1'b1, 3'h7, 9'h000);
    issue(skip_if_bit_low_op, 8'h08, 1'b0, 3'h3, 9'h000);
    issue(skip_if_bit_low_op, 8'hf7, 1'b0, 3'h3, 9'h000);
    issue(add_with_carry_to_file_op, 8'h55, 1'b1, 3'h0, 9'h000);
    issue(rel_jump_op, 8'h00, 1'b0, 3'h0, 9'h100);
    issue(rel_jump_op, 8'h00, 1'b0, 3'h0, 9'h0ff);
    issue(rel_jump_op, 8'h00, 1'b0, 3'h0, 9'h0ff);
    $display("test directed done");
    repeat (400) issue(op_t'(3'(1 + ($unsigned($random(seed)) % 6))), 8'($random(seed)), 1'($random(seed)),
                       3'($random(seed)), 9'($random(seed)));
    $display("test random done");
    @(posedge i_clk);
    i_valid <= 1'b0;
    for (int k = 0; k < 20 && notes.size() > 0; k++) @(posedge i_clk);
    if (notes.size() != 0) n_fail++;
    summarize();
  end

  // ****************************************
  // Result watcher
  // ****************************************
  always @(posedge i_clk) seen <= i_valid;

  always @(negedge i_clk) begin
    if (seen) begin
      if (notes.size() == 0) begin
        check(16'h0001, 16'h0000);
      end else begin
        exp_n = notes.pop_front();
        check(16'(o_accum), 16'(exp_n.accum));
        check(16'({o_carry, o_half_overflow_bit, o_zero}), 16'(exp_n.flags));
        check(16'(o_program_counter), 16'(exp_n.pc));
        check(16'(o_idle_slot), 16'(exp_n.idle));
        check(16'(o_fwr), 16'(exp_n.fwr));
        if (exp_n.fwr) begin
          check(16'(o_fwr_addr), 16'(exp_n.addr));
          check(16'(o_fwr_data), 16'(exp_n.data));
        end
      end
    end
  end
endmodule : tb_cpu_exec
